// >>> chip_select_bank.sv
`timescale 1ns/1ns
`default_nettype none


module chip_select_bank
	import chip_select_pkg::*;
#(
	parameter int NUM_SEL = 3
) (
	// Clock and reset
	input  wire logic        I_CLK,
	input  wire logic        I_SYS_RST,
	// Configuration register port
	input  wire logic [7:0]  I_FIRST_INDEX,
	input  wire logic [7:0]  I_SECOND_INDEX_WDATA,
	input  wire logic        I_SECOND_INDEX_WR,
	input  wire logic [7:0]  I_DATA_WDATA,
	input  wire logic        I_DATA_WR,
	input  wire logic        I_DATA_RD,
	output logic [7:0]       O_SECOND_INDEX,
	output logic [7:0]       O_RDATA,
	output logic             O_RDATA_VALID,
	// Host I/O bus
	input  wire logic [15:0] I_ADDR,
	input  wire logic        I_AEN,
	input  wire logic        I_RD_N,
	input  wire logic        I_WR_N,
	// Select outputs
	output logic             O_SELECT_OUT_ZERO_N,
	output logic             O_SELECT_OUT_ONE_N,
	output logic             O_SELECT_OUT_TWO_N
);

	logic [3:0]          second_index_reg;
	logic [7:0]          base_high_reg [NUM_SEL];
	logic [7:0]          base_low_reg  [NUM_SEL];
	logic [7:0]          config_reg    [NUM_SEL];
	logic                bank_sel;
	logic [1:0]          slot;
	logic [1:0]          field;
	logic                slot_ok;
	logic [7:0]          rdata_next;
	logic [NUM_SEL-1:0]  sel_n;
	access_state_t       acc_reg;

	// ----------------------------------------------------------------
	// Index decode
	// ----------------------------------------------------------------
	// bank chosen by first index.
	assign bank_sel = (I_FIRST_INDEX == BANK_FIRST_INDEX);
	// Each output owns four consecutive indexes; the fourth is reserved.
	assign slot     = second_index_reg[3:2];
	assign field    = second_index_reg[1:0];
	assign slot_ok  = (int'(slot) < NUM_SEL) && (field != 2'b11);

	always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			second_index_reg <= 4'h0;
		end else if (bank_sel && I_SECOND_INDEX_WR) begin
			second_index_reg <= I_SECOND_INDEX_WDATA[3:0];
		end
	end

	always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			O_SECOND_INDEX <= 8'h00;
		end else begin
			O_SECOND_INDEX <= {4'h0, second_index_reg};
		end
	end

	// ----------------------------------------------------------------
	// Register file
	// ----------------------------------------------------------------
	// cleared on reset, written by index.
	// Writes to reserved indexes are dropped; software must avoid them.
	always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			for (int i = 0; i < NUM_SEL; i++) begin
				base_high_reg[i] <= REG_RESET_VALUE;
				base_low_reg[i]  <= REG_RESET_VALUE;
				config_reg[i]    <= REG_RESET_VALUE;
			end
		end else if (bank_sel && I_DATA_WR && slot_ok) begin
			case (field)
				SEL0_BASE_HIGH_IDX[1:0]: base_high_reg[slot] <= I_DATA_WDATA;
				SEL0_BASE_LOW_IDX[1:0]:  base_low_reg[slot]  <= I_DATA_WDATA;
				SEL0_CONFIG_IDX[1:0]:    config_reg[slot]    <= I_DATA_WDATA;
				default: ;
			endcase
		end
	end

	// Readback; reserved indexes read as zero.
	always_comb begin
		rdata_next = RESERVED_READ;
		if (slot_ok) begin
			case (field)
				SEL0_BASE_HIGH_IDX[1:0]: rdata_next = base_high_reg[slot];
				SEL0_BASE_LOW_IDX[1:0]:  rdata_next = base_low_reg[slot];
				SEL0_CONFIG_IDX[1:0]:    rdata_next = config_reg[slot];
				default:                 rdata_next = RESERVED_READ;
			endcase
		end
	end

	// Read answer comes one cycle after the strobe.
	always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			O_RDATA       <= 8'h00;
			O_RDATA_VALID <= 1'b0;
			acc_reg       <= ACC_IDLE;
		end else begin
			O_RDATA_VALID <= bank_sel && I_DATA_RD;
			if (bank_sel && I_DATA_RD) begin
				O_RDATA <= rdata_next;
			end
			case (acc_reg)
				ACC_IDLE: acc_reg <= (bank_sel && I_DATA_RD) ? ACC_BUSY : ACC_IDLE;
				// Back-to-back reads keep the answer phase open, as valid does.
				ACC_BUSY: acc_reg <= (bank_sel && I_DATA_RD) ? ACC_BUSY : ACC_IDLE;
				default:  acc_reg <= ACC_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Decoders
	// ----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < NUM_SEL; g++) begin : g_sel
			select_cfg_if cfg ();
			assign cfg.base        = {base_high_reg[g], base_low_reg[g]};
			assign cfg.config_byte = config_reg[g];
			select_decoder u_dec (
				.i_clk   (I_CLK),
				.i_rst   (I_SYS_RST),
				.cfg     (cfg),
				.i_addr  (I_ADDR),
				.i_aen   (I_AEN),
				.i_rd_n  (I_RD_N),
				.i_wr_n  (I_WR_N),
				.o_sel_n (sel_n[g])
			);
		end
	endgenerate

	// Decoder outputs are already flops; these are pure wires.
	assign O_SELECT_OUT_ZERO_N = sel_n[0];
	assign O_SELECT_OUT_ONE_N  = sel_n[1];
	assign O_SELECT_OUT_TWO_N  = sel_n[2];

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	// index upper nibble reads zero.
	idx_high_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
		O_SECOND_INDEX[7:4] == 4'h0)
		else $error("second index upper bits nonzero");

	sequence cfg_write_s;
		bank_sel && I_DATA_WR && slot_ok && !I_SECOND_INDEX_WR;
	endsequence
	wr_readback_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
		(cfg_write_s ##1 (bank_sel && I_DATA_RD && !I_DATA_WR && !I_SECOND_INDEX_WR))
		|=> (O_RDATA == $past(I_DATA_WDATA, 2)))
		else $error("register readback mismatch");

	bank_gate_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
		!bank_sel |=> $stable(second_index_reg))
		else $error("index changed while bank not selected");

	rd_answer_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
		(bank_sel && I_DATA_RD) |=> (O_RDATA_VALID && (acc_reg == ACC_BUSY)))
		else $error("read answer missing");

endmodule : chip_select_bank

`default_nettype wire

// >>> chip_select_bank_tb.sv
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------------------------------
// Register and decode bench
// ----------------------------------------------------------------
module chip_select_bank_tb;
	import chip_select_pkg::*;
	logic        I_CLK = 1'b0, I_SYS_RST = 1'b1;
	logic [7:0]  I_FIRST_INDEX = BANK_FIRST_INDEX, I_SECOND_INDEX_WDATA = 8'h00;
	logic [7:0]  I_DATA_WDATA = 8'h00;
	logic        I_SECOND_INDEX_WR = 1'b0, I_DATA_WR = 1'b0, I_DATA_RD = 1'b0;
	logic [15:0] I_ADDR = 16'h0000;
	logic        I_AEN = 1'b1, I_RD_N = 1'b1, I_WR_N = 1'b1;
	logic [7:0]  O_SECOND_INDEX, O_RDATA;
	logic        O_RDATA_VALID;
	logic [2:0]  sel_n;
	logic [7:0]  count [3];
	int          miscompares = 0, n_checks = 0, cycles = 0;
	// Entries: config, address, {aen, rd_n, wr_n}, expected {two, one, zero}.
	logic [31:0] vec [14] = '{32'h20_1234_1_6, 32'h20_1234_2_7, 32'h20_1234_5_7,
		32'h10_1234_2_6, 32'h10_1234_1_7, 32'h40_1234_3_6, 32'h70_1234_5_7,
		32'h4F_123B_3_6, 32'h41_1235_3_6, 32'h41_1236_3_7, 32'hC0_1ABC_3_6,
		32'hC0_2234_3_7, 32'h00_1234_1_7, 32'h00_5678_3_3};

	chip_select_bank i_chip_select_bank (.I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST),
		.I_FIRST_INDEX(I_FIRST_INDEX), .I_SECOND_INDEX_WDATA(I_SECOND_INDEX_WDATA),
		.I_SECOND_INDEX_WR(I_SECOND_INDEX_WR), .I_DATA_WDATA(I_DATA_WDATA),
		.I_DATA_WR(I_DATA_WR), .I_DATA_RD(I_DATA_RD), .O_SECOND_INDEX(O_SECOND_INDEX),
		.O_RDATA(O_RDATA), .O_RDATA_VALID(O_RDATA_VALID), .I_ADDR(I_ADDR),
		.I_AEN(I_AEN), .I_RD_N(I_RD_N), .I_WR_N(I_WR_N),
		.O_SELECT_OUT_ZERO_N(sel_n[0]), .O_SELECT_OUT_ONE_N(sel_n[1]),
		.O_SELECT_OUT_TWO_N(sel_n[2]));
	select_peripheral_model i_select_peripheral_model (.i_clk(I_CLK), .i_rst(I_SYS_RST),
		.i_sel_n(sel_n), .o_count(count));

	// Free-running clock; the cycle counter cuts a hang short.
	initial begin
		forever #5 I_CLK = ~I_CLK;
	end
	always @(posedge I_CLK) begin
		cycles++;
		if (cycles == 2000) begin
			miscompares++;
			$display("ERROR at %0t: timeout", $time);
			report_and_stop();
		end
	end

	task automatic tick;
		@(posedge I_CLK);
		@(negedge I_CLK);
	endtask : tick
	task automatic wr_idx(input logic [7:0] idx);
		I_SECOND_INDEX_WDATA = idx;
		I_SECOND_INDEX_WR = 1'b1;
		tick();
		I_SECOND_INDEX_WR = 1'b0;
	endtask : wr_idx
	task automatic wr_reg(input logic [7:0] idx, input logic [7:0] d);
		wr_idx(idx);
		I_DATA_WDATA = d;
		I_DATA_WR = 1'b1;
		tick();
		I_DATA_WR = 1'b0;
	endtask : wr_reg
	task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR at %0t: byte %h expected %h", $time, got, exp);
		end
	endtask : cmp8
	task automatic cmp3(input logic [2:0] got, input logic [2:0] exp);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR at %0t: selects %b expected %b", $time, got, exp);
		end
	endtask : cmp3
	// Read strobe is taken at one edge; valid and data are settled by the next fall.
	task automatic chk_reg(input logic [7:0] idx, input logic [7:0] exp);
		wr_idx(idx);
		I_DATA_RD = 1'b1;
		tick();
		I_DATA_RD = 1'b0;
		cmp8({7'h00, O_RDATA_VALID}, 8'h01);
		cmp8(O_RDATA, exp);
	endtask : chk_reg
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : report_and_stop

	initial begin
		repeat (4) @(posedge I_CLK);
		@(negedge I_CLK);
		I_SYS_RST = 1'b0;
		for (int i = 0; i < 11; i++)
			if (i % 4 != 3)
				chk_reg(8'(i), REG_RESET_VALUE);
		// An index of 12h can only reach index 02h.
		wr_reg(8'h12, 8'h5A);
		chk_reg(8'h02, 8'h5A);
		wr_idx(8'h1A);
		tick();
		cmp8(O_SECOND_INDEX, 8'h0A);
		$display("test reset_and_index done");
		for (int i = 0; i < 3; i++) begin
			wr_reg(8'(4 * i), 8'hA0 | 8'(i));
			wr_reg(8'(4 * i + 1), 8'h50 | 8'(i));
			wr_reg(8'(4 * i + 2), 8'h0F ^ 8'(i));
		end
		I_FIRST_INDEX = 8'h00;
		wr_reg(8'h00, 8'hFF);
		I_FIRST_INDEX = BANK_FIRST_INDEX;
		for (int i = 0; i < 3; i++) begin
			chk_reg(8'(4 * i), 8'hA0 | 8'(i));
			chk_reg(8'(4 * i + 1), 8'h50 | 8'(i));
			chk_reg(8'(4 * i + 2), 8'h0F ^ 8'(i));
		end
		// A read right behind the write must already see the new byte.
		wr_reg(8'h06, 8'h3C);
		I_DATA_RD = 1'b1;
		tick();
		I_DATA_RD = 1'b0;
		cmp8(O_RDATA, 8'h3C);
		$display("test readback done");
		wr_reg(8'h00, 8'h12);
		wr_reg(8'h01, 8'h34);
		wr_reg(8'h04, 8'h12);
		wr_reg(8'h05, 8'h34);
		wr_reg(8'h06, 8'h00);
		wr_reg(8'h08, 8'h56);
		wr_reg(8'h09, 8'h78);
		wr_reg(8'h0A, 8'h40);
		// Each entry returns the bus to idle so every select is a fresh pulse.
		foreach (vec[k]) begin
			wr_reg({4'h0, SEL0_CONFIG_IDX}, vec[k][31:24]);
			I_ADDR = vec[k][23:8];
			{I_AEN, I_RD_N, I_WR_N} = vec[k][6:4];
			tick();
			cmp3(sel_n, vec[k][2:0]);
			{I_AEN, I_RD_N, I_WR_N} = 3'h7;
			tick();
		end
		cmp8(count[0], 8'h06);
		cmp8(count[1], 8'h00);
		cmp8(count[2], 8'h01);
		$display("test decode done");
		report_and_stop();
	end
endmodule : chip_select_bank_tb

`default_nettype wire

// >>> chip_select_pkg.sv
`default_nettype none

package chip_select_pkg;

	// ----------------------------------------------------------------
	// Register indexes of the chip-select bank
	// ----------------------------------------------------------------
	localparam logic [7:0] BANK_FIRST_INDEX   = 8'h23;
	localparam logic [3:0] SEL0_BASE_HIGH_IDX = 4'h0;
	localparam logic [3:0] SEL0_BASE_LOW_IDX  = 4'h1;
	localparam logic [3:0] SEL0_CONFIG_IDX    = 4'h2;
	localparam logic [3:0] SEL1_BASE_HIGH_IDX = 4'h4;
	localparam logic [3:0] SEL1_BASE_LOW_IDX  = 4'h5;
	localparam logic [3:0] SEL1_CONFIG_IDX    = 4'h6;
	localparam logic [3:0] SEL2_BASE_HIGH_IDX = 4'h8;
	localparam logic [3:0] SEL2_BASE_LOW_IDX  = 4'h9;
	localparam logic [3:0] SEL2_CONFIG_IDX    = 4'hA;
	localparam logic [7:0] REG_RESET_VALUE    = 8'h00;
	localparam logic [7:0] RESERVED_READ      = 8'h00;

	// ----------------------------------------------------------------
	// Configuration byte fields
	// ----------------------------------------------------------------
	localparam int CFG_MASK_LSB     = 0;
	localparam int CFG_MASK_MSB     = 3;
	localparam int CFG_ON_WRITE     = 4;
	localparam int CFG_ON_READ      = 5;
	localparam int CFG_NO_STROBE    = 6;
	localparam int CFG_MASK_LOW12   = 7;
	localparam logic [15:0] LOW12_MASK = 16'h0FFF;

	// Host register access states.
	typedef enum logic [1:0] {
		ACC_IDLE = 2'b00,
		ACC_BUSY = 2'b01
	} access_state_t;

endpackage : chip_select_pkg

`default_nettype wire

// >>> select_cfg_if.sv
`timescale 1ns/1ns
`default_nettype none

// Carries one output's programmed decode settings to its decoder.
interface select_cfg_if;
	logic [15:0] base;
	logic [7:0]  config_byte;
	modport source (output base, output config_byte);
	modport sink   (input base, input config_byte);
endinterface : select_cfg_if

`default_nettype wire

// >>> select_decoder.sv
`timescale 1ns/1ns
`default_nettype none

module select_decoder
	import chip_select_pkg::*;
(
	// Clock and reset
	input  wire logic    i_clk,
	input  wire logic    i_rst,
	// Settings
	select_cfg_if.sink   cfg,
	// Host bus
	input  wire logic [15:0] i_addr,
	input  wire logic    i_aen,
	input  wire logic    i_rd_n,
	input  wire logic    i_wr_n,
	// Select output
	output logic         o_sel_n
);

	logic [15:0] ignore_bits;
	logic        addr_hit;
	logic        strobe_ok;

	// ----------------------------------------------------------------
	// Address compare
	// ----------------------------------------------------------------
	// low line masks, wide mask.
	always_comb begin
		ignore_bits = {12'h000, cfg.config_byte[CFG_MASK_MSB:CFG_MASK_LSB]};
		if (cfg.config_byte[CFG_MASK_LOW12]) begin
			ignore_bits = ignore_bits | LOW12_MASK;
		end
	end

	assign addr_hit = ((i_addr ^ cfg.base) & ~ignore_bits) == 16'h0000;

	assign strobe_ok = cfg.config_byte[CFG_NO_STROBE]
		| (cfg.config_byte[CFG_ON_WRITE] & ~i_wr_n)
		| (cfg.config_byte[CFG_ON_READ] & ~i_rd_n);

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_sel_n <= 1'b1;
		end else begin
			o_sel_n <= ~(addr_hit & strobe_ok & ~i_aen);
		end
	end

	sel_aen_a: assert property (@(posedge i_clk) disable iff (i_rst)
		$past(i_aen) |-> o_sel_n)
		else $error("select asserted while address enable high");

	no_strobe_a: assert property (@(posedge i_clk) disable iff (i_rst)
		(!i_aen && addr_hit && cfg.config_byte[CFG_NO_STROBE]) |=> !o_sel_n)
		else $error("strobe independent select missed");

	on_write_a: assert property (@(posedge i_clk) disable iff (i_rst)
		(!i_aen && addr_hit && cfg.config_byte[CFG_ON_WRITE] && !i_wr_n) |=> !o_sel_n)
		else $error("write qualified select missed");

	on_read_a: assert property (@(posedge i_clk) disable iff (i_rst)
		(!i_aen && addr_hit && cfg.config_byte[CFG_ON_READ] && !i_rd_n) |=> !o_sel_n)
		else $error("read qualified select missed");

	strobe_off_a: assert property (@(posedge i_clk) disable iff (i_rst)
		(!cfg.config_byte[CFG_NO_STROBE] && i_rd_n && i_wr_n) |=> o_sel_n)
		else $error("select without qualifying strobe");

	mask_low_a: assert property (@(posedge i_clk) disable iff (i_rst)
		(!cfg.config_byte[CFG_MASK_LOW12] && !cfg.config_byte[CFG_MASK_LSB]
		 && (i_addr[0] != cfg.base[0])) |=> o_sel_n)
		else $error("select despite unmasked A0 mismatch");

	mask_high_a: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_addr[15:12] != cfg.base[15:12]) |=> o_sel_n)
		else $error("select despite high address mismatch");

endmodule : select_decoder

`default_nettype wire

// >>> select_peripheral_model.sv
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------------------------------
// Peripheral that counts how often each select line picks it
// ----------------------------------------------------------------
module select_peripheral_model (
	// Clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_rst,
	// Select lines, active low
	input  wire logic [2:0] i_sel_n,
	// Pulse counts, one byte per line
	output logic [7:0]      o_count [3]
);
	logic [2:0] prev_reg;

	// A pulse is counted once, at its leading edge, so a long select is not seen twice.
	// The edge history resets to the idle level so no false edge follows reset.
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			prev_reg <= 3'h7;
			for (int i = 0; i < 3; i++) begin
				o_count[i] <= 8'h00;
			end
		end else begin
			prev_reg <= i_sel_n;
			for (int i = 0; i < 3; i++) begin
				if (prev_reg[i] && !i_sel_n[i])
					o_count[i] <= o_count[i] + 8'h01;
			end
		end
	end
endmodule : select_peripheral_model

`default_nettype wire
